/* File: rtl/spi_slave_framing.sv */
// serial control port slave: framing, instruction decode, byte transfers
`timescale 1ns/10ps

// How it works
// - while select is high every clock and data transition is ignored.
// - select going high returns the port to ready so the next low starts an instruction.
// - a rise during the instruction or the first data byte drops the transfer and commits nothing.
// - in a cut multi-byte transfer every complete byte takes effect and the rest are abandoned.
// - each address selects exactly one 8-bit location.
// - outgoing data changes on the falling clock edge and incoming data is taken on the rising edge.
// - the 16-bit instruction has read-high write-low in bit 15 and the start address in bits 14 to 0.
// - after the instruction data moves in whole bytes, one per address.
// - undefined addresses proceed normally, writes still strobed out to the register file and reads returning zero.
module spi_slave_framing (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // serial pins
  input  wire logic                   cs_n_in,
  input  wire logic                   sclk_in,
  input  wire logic                   sdi_in,
  output logic                        sdo_out,
  output logic                        sdo_oe_n_out,
  // register file side
  output logic                        reg_wr_out,
  output logic                        reg_rd_out,
  output logic [spi_framing_pkg::ADDR_W-1:0]    reg_addr_out,
  output logic [spi_framing_pkg::BYTE_BITS-1:0] reg_wdata_out,
  input  wire logic [spi_framing_pkg::BYTE_BITS-1:0] reg_rdata_in,
  input  wire logic                   reg_hit_in,
  // status
  output logic                        busy_out
);
  spi_pins_if pins ();

  spi_pin_sampler u_sampler (
    .clk_in  (clk_in),
    .rst_in  (rst_in),
    .cs_n_in (cs_n_in),
    .sclk_in (sclk_in),
    .sdi_in  (sdi_in),
    .pins    (pins.sampler)
  );

  // frame state
  spi_framing_pkg::port_state_t           state_r;
  spi_framing_pkg::port_state_t           state_nxt;
  logic                                   read_r;
  logic                                   read_nxt;
  logic [spi_framing_pkg::ADDR_W-1:0]     addr_r;
  logic [spi_framing_pkg::ADDR_W-1:0]     addr_nxt;

  // shift path
  logic [spi_framing_pkg::CNT_W-1:0]      bit_r;
  logic [spi_framing_pkg::CNT_W-1:0]      bit_nxt;
  logic [spi_framing_pkg::INSTR_BITS-1:0] shin_r;
  logic [spi_framing_pkg::INSTR_BITS-1:0] shin_nxt;
  logic [spi_framing_pkg::INSTR_BITS-1:0] shifted;
  logic [spi_framing_pkg::BYTE_BITS-1:0]  wdata_r;
  logic [spi_framing_pkg::BYTE_BITS-1:0]  wdata_nxt;

  // register file strobes
  logic                                   wr_r;
  logic                                   wr_nxt;
  logic                                   rd_r;
  logic                                   rd_nxt;

  // read data path
  logic [spi_framing_pkg::BYTE_BITS-1:0]  tx_r;
  logic [spi_framing_pkg::BYTE_BITS-1:0]  tx_nxt;
  logic                                   load_r;
  logic                                   load_nxt;

  // serial clock edges
  logic                                   sclk_d_r;
  logic                                   sclk_d_nxt;
  logic                                   rise;
  logic                                   fall;

  // edges only count inside a frame
  // limitation: each clock phase must last at least four system clocks
  assign rise    = !pins.cs_n && pins.sclk && !sclk_d_r;
  assign fall    = !pins.cs_n && !pins.sclk && sclk_d_r;
  assign shifted = {shin_r[spi_framing_pkg::INSTR_BITS-2:0], pins.sdi};

  always_comb begin
    state_nxt  = state_r;
    bit_nxt    = bit_r;
    shin_nxt   = shin_r;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    read_nxt   = read_r;
    // strobes last a single cycle
    wr_nxt     = 1'b0;
    rd_nxt     = 1'b0;
    if (pins.cs_n) begin
      // partial words are thrown away, committed bytes stay
      state_nxt = spi_framing_pkg::ST_READY;
      bit_nxt   = spi_framing_pkg::CNT_ZERO;
      shin_nxt  = spi_framing_pkg::INSTR_ZERO;
      read_nxt  = 1'b0;
    end else begin
      // select low: step through the frame
      case (state_r)
        spi_framing_pkg::ST_READY: begin
          state_nxt = spi_framing_pkg::ST_INSTR;
          bit_nxt   = spi_framing_pkg::CNT_ZERO;
        end
        spi_framing_pkg::ST_INSTR: begin
          if (rise) begin
            shin_nxt = shifted;
            bit_nxt  = bit_r + spi_framing_pkg::CNT_ONE;
            if (bit_r == spi_framing_pkg::INSTR_LAST) begin
              state_nxt = spi_framing_pkg::ST_DATA;
              bit_nxt   = spi_framing_pkg::CNT_ZERO;
              read_nxt  = shifted[spi_framing_pkg::RW_BIT];
              addr_nxt  = shifted[spi_framing_pkg::ADDR_W-1:0];
              rd_nxt    = shifted[spi_framing_pkg::RW_BIT];
            end
          end
        end
        spi_framing_pkg::ST_DATA: begin
          if (rise) begin
            shin_nxt = shifted;
            bit_nxt  = bit_r + spi_framing_pkg::CNT_ONE;
            if (bit_r == spi_framing_pkg::BYTE_LAST) begin
              // a byte counts only once all eight bits are in
              bit_nxt   = spi_framing_pkg::CNT_ZERO;
              wdata_nxt = shifted[spi_framing_pkg::BYTE_BITS-1:0];
              wr_nxt    = !read_r;
              // the address advances past defined registers as well
              addr_nxt  = addr_r + spi_framing_pkg::ADDR_STEP;
              rd_nxt    = read_r;
            end
          end
        end
        default: begin
          state_nxt = spi_framing_pkg::ST_READY;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r  <= spi_framing_pkg::ST_READY;
      bit_r    <= spi_framing_pkg::CNT_ZERO;
      shin_r   <= spi_framing_pkg::INSTR_ZERO;
      addr_r   <= spi_framing_pkg::ADDR_RESET;
      wdata_r  <= spi_framing_pkg::BYTE_ZERO;
      read_r   <= 1'b0;
      wr_r     <= 1'b0;
      rd_r     <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      bit_r    <= bit_nxt;
      shin_r   <= shin_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      read_r   <= read_nxt;
      wr_r     <= wr_nxt;
      rd_r     <= rd_nxt;
    end
  end

  // edge detector resets to the idle clock level, so no false edge follows
  always_comb begin
    sclk_d_nxt = pins.sclk;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_d_nxt;
    end
  end

  // read data is latched the cycle after the fetch strobe
  always_comb begin
    tx_nxt   = tx_r;
    load_nxt = rd_r && !pins.cs_n;
    if (load_r) begin
      tx_nxt = reg_hit_in ? reg_rdata_in
                          : spi_framing_pkg::BYTE_ZERO;
    end
    // byte boundary falls keep the freshly fetched msb in place
    if (fall && read_r && (state_r == spi_framing_pkg::ST_DATA) &&
        (bit_r != spi_framing_pkg::CNT_ZERO)) begin
      tx_nxt = {tx_r[spi_framing_pkg::BYTE_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_r   <= spi_framing_pkg::BYTE_ZERO;
      load_r <= 1'b0;
    end else begin
      tx_r   <= tx_nxt;
      load_r <= load_nxt;
    end
  end

  // write strobe carries the address of the byte just completed
  // a fetch strobe asks for the byte at reg_addr_out, answered next cycle
  assign reg_wr_out    = wr_r;
  assign reg_rd_out    = rd_r;
  assign reg_addr_out  = wr_r ? addr_r - spi_framing_pkg::ADDR_STEP : addr_r;
  assign reg_wdata_out = wdata_r;
  assign sdo_out       = tx_r[spi_framing_pkg::BYTE_BITS-1];
  // output floats outside a frame and during writes
  assign sdo_oe_n_out  = pins.cs_n || !read_r ||
                         (state_r != spi_framing_pkg::ST_DATA);
  assign busy_out      = (state_r != spi_framing_pkg::ST_READY);
endmodule

/* File: rtl/spi_framing_pkg.sv */
// constants shared by the serial control port slave
package spi_framing_pkg;
  localparam int unsigned INSTR_BITS  = 16;
  localparam int unsigned BYTE_BITS   = 8;
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned RW_BIT      = 15;
  localparam int unsigned CNT_W       = 4;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO     = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE      = 4'h1;
  localparam logic [CNT_W-1:0] INSTR_LAST   = 4'hf;
  localparam logic [CNT_W-1:0] BYTE_LAST    = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_STEP   = 15'h0001;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 15'h0000;
  localparam logic [BYTE_BITS-1:0] BYTE_ZERO = 8'h00;
  localparam logic [INSTR_BITS-1:0] INSTR_ZERO = 16'h0000;
  typedef enum logic [2:0] {
    ST_READY = 3'b001,
    ST_INSTR = 3'b010,
    ST_DATA  = 3'b100
  } port_state_t;
endpackage

/* File: rtl/spi_pins_if.sv */
// synchronised serial pin levels passed from the sampler to the core
`timescale 1ns/10ps
interface spi_pins_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  modport sampler (output cs_n, output sclk, output sdi);
  modport core    (input  cs_n, input  sclk, input  sdi);
endinterface

/* File: rtl/spi_pin_sampler.sv */
// three-stage pin sampler with agreement filter for the serial pins
`timescale 1ns/10ps
module spi_pin_sampler (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // raw pins
  input  wire logic        cs_n_in,
  input  wire logic        sclk_in,
  input  wire logic        sdi_in,
  // filtered levels
  spi_pins_if.sampler      pins
);
  localparam int unsigned N = 3;
  logic [N-1:0] raw;
  logic [N-1:0] s1_r;
  logic [N-1:0] s2_r;
  logic [N-1:0] s3_r;
  logic [N-1:0] lvl_r;
  logic [N-1:0] lvl_nxt;

  assign raw = {cs_n_in, sclk_in, sdi_in};

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      // a level is taken only once stages two and three agree
      always_comb begin
        lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
      end
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          // chip select idles high, clock and data low
          s1_r[g]  <= (g == 2);
          s2_r[g]  <= (g == 2);
          s3_r[g]  <= (g == 2);
          lvl_r[g] <= (g == 2);
        end else begin
          s1_r[g]  <= raw[g];
          s2_r[g]  <= s1_r[g];
          s3_r[g]  <= s2_r[g];
          lvl_r[g] <= lvl_nxt[g];
        end
      end
    end
  endgenerate

  assign pins.cs_n = lvl_r[2];
  assign pins.sclk = lvl_r[1];
  assign pins.sdi  = lvl_r[0];
endmodule

/* File: tb/spi_slave_framing_checker.sv */
// port assertions for the serial control port slave
`timescale 1ns/10ps
module spi_slave_framing_checker (
  // watched ports
  input wire logic                              clk_in,
  input wire logic                              rst_in,
  input wire logic                              cs_n_in,
  input wire logic                              sdo_oe_n_out,
  input wire logic                              reg_wr_out,
  input wire logic                              reg_rd_out,
  input wire logic [spi_framing_pkg::ADDR_W-1:0] reg_addr_out,
  input wire logic                              busy_out
);
  logic [2:0]                          hi_r;
  logic [spi_framing_pkg::ADDR_W-1:0] last_r;
  logic                                seen_r;
  // six cycles of high select outlasts the pin sampler latency
  always_ff @(posedge clk_in) begin
    hi_r <= (rst_in || !cs_n_in) ? 3'h0 : hi_r + {2'h0, hi_r != 3'h7};
    seen_r <= (rst_in || !busy_out) ? 1'b0 : seen_r | reg_wr_out;
    if (reg_wr_out) last_r <= reg_addr_out;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_fetch; reg_rd_out; endsequence
  sequence s_drive; ##[1:6] !sdo_oe_n_out; endsequence
  property p_quiet; hi_r >= 3'h6 |-> !reg_wr_out && !reg_rd_out; endproperty
  property p_ready; hi_r >= 3'h6 |-> !busy_out; endproperty
  property p_oe; hi_r >= 3'h6 |-> sdo_oe_n_out; endproperty
  property p_gap; reg_wr_out |=> !reg_wr_out [*8]; endproperty
  property p_rdp; s_fetch |=> !reg_rd_out [*8]; endproperty
  property p_step; reg_wr_out && seen_r |-> reg_addr_out == last_r + 15'h0001;
  endproperty
  property p_drive; s_fetch |-> s_drive; endproperty
  property p_excl; !sdo_oe_n_out |-> !reg_wr_out; endproperty
  a_quiet: assert property (p_quiet)
    else $error("strobe while select high");
  a_ready: assert property (p_ready)
    else $error("not ready after select rise");
  a_oe: assert property (p_oe)
    else $error("data out driven while select high");
  a_gap: assert property (p_gap)
    else $error("write pulses closer than a byte");
  a_rdp: assert property (p_rdp)
    else $error("fetch pulses closer than a byte");
  a_step: assert property (p_step)
    else $error("address did not step by one");
  a_drive: assert property (p_drive)
    else $error("read byte not driven");
  a_excl: assert property (p_excl)
    else $error("write during read");
endmodule
bind spi_slave_framing spi_slave_framing_checker u_spi_slave_framing_checker (
  .clk_in, .rst_in, .cs_n_in, .sdo_oe_n_out, .reg_wr_out, .reg_rd_out,
  .reg_addr_out, .busy_out);

/* File: tb/spi_master_model.sv */
// serial bus master model driving select, clock and data
`timescale 1ns/10ps
module spi_master_model (
  // clock
  input  wire logic clk_in,
  // serial pins
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      sdi_out,
  input  wire logic sdo_in
);
  logic [31:0] rx;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end
  // released data line keeps changing so a stale bit never looks valid
  task automatic hold(input int k);
    repeat (k) begin
      @(negedge clk_in);
      if (cs_n_out) sdi_out = ~sdi_out;
    end
  endtask
  // 800 ns clock: four system clocks per phase, the fastest rate permitted, as the port samples it
  task automatic frame(input logic [31:0] bits, input int n);
    rx = 32'h0000_0000;
    cs_n_out = 1'b0;
    hold(4);
    for (int i = n - 1; i >= 0; i--) begin
      sclk_out = 1'b0;
      sdi_out = bits[i];
      hold(4);
      sclk_out = 1'b1;
      hold(4);
      rx = {rx[30:0], sdo_in};
    end
    sclk_out = 1'b0;
    hold(4);
    cs_n_out = 1'b1;
  endtask
  // clock wiggles with select high, on purpose
  task automatic noise();
    repeat (6) begin
      sclk_out = ~sclk_out;
      hold(4);
    end
  endtask
endmodule

/* File: tb/spi_slave_framing_tb_top.sv */
// testbench for the serial control port slave
`timescale 1ns/10ps
module spi_slave_framing_tb_top;
  logic                                 clk_in = 1'b0;
  logic                                 rst_in = 1'b1;
  logic                                 cs_n, sclk, sdi, sdo, oe_n;
  logic                                 wr, rd, hit, busy;
  logic [spi_framing_pkg::ADDR_W-1:0]    addr;
  logic [spi_framing_pkg::BYTE_BITS-1:0] wdata, rdata;
  logic [22:0]                          wq[$];
  int                                   fails = 0;
  int                                   cmp_count = 0;
  int                                   rd_cnt = 0;
  int                                   oe_cnt = 0;
  always #50 clk_in = ~clk_in;
  // low sixteen bytes defined; junk above shows that undefined reads clear
  assign hit = addr < 15'h0010;
  assign rdata = hit ? {addr[3:0], ~addr[3:0]} : 8'ha5;
  always @(posedge clk_in) if (wr === 1'b1) wq.push_back({addr, wdata});
  always @(posedge clk_in) if (rd === 1'b1) rd_cnt++;
  always @(posedge clk_in) if (oe_n === 1'b0) oe_cnt++;
  spi_slave_framing u_spi_slave_framing (.clk_in, .rst_in, .cs_n_in(cs_n),
    .sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(oe_n),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_hit_in(hit),
    .busy_out(busy));
  spi_master_model u_spi_master_model (.clk_in, .cs_n_out(cs_n),
    .sclk_out(sclk), .sdi_out(sdi), .sdo_in(sdo));
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic run(input logic [31:0] bits, input int n);
    wq.delete();
    rd_cnt = 0;
    oe_cnt = 0;
    u_spi_master_model.frame(bits, n);
    u_spi_master_model.hold(8);
  endtask
  task automatic t_write();
    run({16'h0003, 8'h5a, 8'hc3}, 32);
    chk(wq.size() == 2 && wq[0] === {15'h0003, 8'h5a} &&
        wq[1] === {15'h0004, 8'hc3}, "write burst");
    chk(busy === 1'b0, "busy after frame");
    chk(rd_cnt == 0 && oe_cnt == 0, "read activity in write");
    run({16'h0100, 8'h77}, 24);
    chk(wq.size() == 1 && wq[0] === {15'h0100, 8'h77}, "undef write");
    $display("write test done");
  endtask
  task automatic t_read();
    run({16'h8002, 16'h0000}, 32);
    chk(u_spi_master_model.rx[15:0] === 16'h2d3c, "read burst");
    chk(wq.size() == 0, "write in read");
    chk(rd_cnt == 3 && oe_cnt > 0, "fetch count");
    chk(oe_n === 1'b1, "data out not released");
    run({16'hffff, 8'h00}, 24);
    chk(u_spi_master_model.rx[7:0] === 8'h00, "undef read");
    $display("read test done");
  endtask
  task automatic t_abort();
    run(32'h0000_03ff, 10);
    chk(wq.size() == 0, "cut instruction");
    run({16'h0005, 5'h1f}, 21);
    chk(wq.size() == 0, "cut first byte");
    run({16'h0006, 8'h11, 3'h7}, 27);
    chk(wq.size() == 1 && wq[0] === {15'h0006, 8'h11}, "cut second");
    run({16'h0001, 8'h42}, 24);
    chk(wq.size() == 1 && wq[0] === {15'h0001, 8'h42}, "restart");
    $display("abort test done");
  endtask
  task automatic t_idle();
    wq.delete();
    u_spi_master_model.noise();
    u_spi_master_model.hold(8);
    chk(wq.size() == 0 && busy === 1'b0, "select high activity");
    run({16'h0002, 8'h99}, 24);
    chk(wq.size() == 1 && wq[0] === {15'h0002, 8'h99}, "after noise");
    $display("idle test done");
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    summarize();
  end
  initial begin
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    u_spi_master_model.hold(4);
    t_write();
    t_read();
    t_abort();
    t_idle();
    summarize();
  end
endmodule
